// ---- src/otg_session_defs.svh ----
`ifndef OTG_SESSION_DEFS_SVH
`define OTG_SESSION_DEFS_SVH

////////////////////////////////////////////////////////////////////////////
// register byte offsets on the avalon slave
`define OFS_DEV_CTRL        6'h00
`define OFS_IRQ_STATUS      6'h04
`define OFS_IRQ_MASK        6'h08
`define OFS_EP_SELECT       6'h0c
`define OFS_TX_SIZE         6'h10
`define OFS_RX_SIZE         6'h14
`define OFS_TX_ADDR         6'h18
`define OFS_RX_ADDR         6'h1c

////////////////////////////////////////////////////////////////////////////
// device control and status field positions
`define DCS_B_ROLE          7
`define DCS_FULL_SPEED      6
`define DCS_LOW_SPEED       5
`define DCS_VBUS_HI         4
`define DCS_VBUS_LO         3
`define DCS_HOST_ROLE       2
`define DCS_SESSION         0

// vbus level encodings
`define VBUS_BELOW_SESS_END 2'h0
`define VBUS_ABOVE_SESS_END 2'h1
`define VBUS_ABOVE_A_VALID  2'h2
`define VBUS_ABOVE_VBUS_VLD 2'h3

// interrupt status bit positions
`define IRQ_SESS_START      0
`define IRQ_SESS_END        1
`define IRQ_VBUS_CHANGE     2
`define IRQ_SRP_START       3
`define IRQ_W               4

////////////////////////////////////////////////////////////////////////////
// endpoint buffer configuration
`define NUM_DYN_EP          4
`define NUM_EP              5
`define SZ_CFG_W            5
`define ADDR_CFG_W          13
`define EP_SEL_W            3
`define SZ_DOUBLE_BIT       4
`define SZ_BIAS             5'h03
`define BUF_BASE_W          16
`define BUF_BYTES_W         20
`define EP0_SIZE_CODE       4'h3
`define EP0_START           13'h0000

////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_IRQ_MASK        4'h0
`define RST_EP_SELECT       3'h0
`define RST_WORD            32'h0000_0000

`endif

// ---- src/otg_session_pkg.sv ----
package otg_session_pkg;
`include "otg_session_defs.svh"

    // avalon access phase: request seen, then answered
    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_phase_t;

    // whole state of the session and configuration logic
    typedef struct packed {
        bus_phase_t                                   phase;
        logic [31:0]                                  rdata;
        logic                                         session;
        logic                                         b_role;
        logic [1:0]                                   vbus;
        logic                                         soft_disc;
        logic                                         srp_pulse;
        logic [`IRQ_W-1:0]                            irq_status;
        logic [`IRQ_W-1:0]                            irq_mask;
        logic [`EP_SEL_W-1:0]                         ep_sel;
        logic [`NUM_DYN_EP-1:0][`SZ_CFG_W-1:0]        tx_size;
        logic [`NUM_DYN_EP-1:0][`SZ_CFG_W-1:0]        rx_size;
        logic [`NUM_DYN_EP-1:0][`ADDR_CFG_W-1:0]      tx_addr;
        logic [`NUM_DYN_EP-1:0][`ADDR_CFG_W-1:0]      rx_addr;
    } ctrl_state_t;

    // registered placement of one endpoint buffer
    typedef struct packed {
        logic [`BUF_BASE_W-1:0]                       base;
        logic [`BUF_BYTES_W-1:0]                      bytes;
    } map_state_t;

endpackage : otg_session_pkg

// ---- src/pin_sync.sv ----
`timescale 1ns/1ps

// two-flop synchroniser for asynchronous pin levels
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] sync_o
);

    // stage 1 is read only by stage 0 (metastability guard)
    logic [1:0][WIDTH-1:0] st;       // [1] first flop, [0] second
    logic [1:0][WIDTH-1:0] next_st;  // next value

    // shift the pin through both stages
    always_comb begin
        next_st    = st;
        next_st[1] = pin_i;
        next_st[0] = st[1];
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st[0];

endmodule : pin_sync

// ---- src/ep_buffer_map.sv ----
`timescale 1ns/1ps
`include "otg_session_defs.svh"

// turns a size code, double flag and start unit into byte figures
module ep_buffer_map
    import otg_session_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    input  wire logic [3:0]               size_code_i,
    input  wire logic                     double_i,
    input  wire logic [`ADDR_CFG_W-1:0]   start_i,
    output logic      [`BUF_BASE_W-1:0]   base_o,
    output logic      [`BUF_BYTES_W-1:0]  bytes_o
);

    map_state_t st;       // registered placement
    map_state_t next_st;  // next value
    logic [4:0] shift;    // log2 of the buffer length

    always_comb begin
        shift         = {1'b0, size_code_i} + `SZ_BIAS + {4'h0, double_i};
        next_st.bytes = `BUF_BYTES_W'(1) << shift;
        // start is kept in units of eight bytes
        next_st.base  = {start_i, 3'b000};
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign base_o  = st.base;
    assign bytes_o = st.bytes;

    a_size_formula: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> bytes_o == (`BUF_BYTES_W'(1) <<
            ({1'b0, $past(size_code_i)} + 5'h03 + {4'h0, $past(double_i)})))
        else $error("buffer length does not follow size code");

endmodule : ep_buffer_map

// ---- src/otg_session_ctrl.sv ----
`timescale 1ns/1ps
`include "otg_session_defs.svh"

module otg_session_ctrl
    import otg_session_pkg::*;
(
    input  wire logic                             CLOCK_I,
    input  wire logic                             RST_B_I,
    input  wire logic [5:0]                       AVS_ADDRESS_I,
    input  wire logic                             AVS_READ_I,
    input  wire logic                             AVS_WRITE_I,
    input  wire logic [31:0]                      AVS_WRITEDATA_I,
    input  wire logic [3:0]                       AVS_BYTEENABLE_I,
    output logic      [31:0]                      AVS_READDATA_O,
    output logic                                  AVS_WAITREQUEST_O,
    input  wire logic                             ID_I,
    input  wire logic                             ABOVE_SESS_END_I,
    input  wire logic                             ABOVE_A_VALID_I,
    input  wire logic                             ABOVE_VBUS_VALID_I,
    input  wire logic                             SUSPEND_I,
    output logic                                  SESSION_O,
    output logic                                  SRP_START_O,
    output logic                                  SOFT_DISCONNECT_O,
    output logic                                  IRQ_O,
    output logic [`NUM_EP*`BUF_BASE_W-1:0]        TX_BUF_BASE_O,
    output logic [`NUM_EP*`BUF_BYTES_W-1:0]       TX_BUF_SIZE_O,
    output logic [`NUM_EP*`BUF_BASE_W-1:0]        RX_BUF_BASE_O,
    output logic [`NUM_EP*`BUF_BYTES_W-1:0]       RX_BUF_SIZE_O
);
    import otg_session_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    ctrl_state_t               st;           // all registered state
    ctrl_state_t               next_st;      // next value of the state
    logic [4:0]                pins;         // synchronised pin levels
    logic [1:0]                level;        // encoded vbus level
    logic                      suspended;    // link is in suspend
    logic                      b_pin;        // id pin says B device
    logic                      req;          // read or write pending
    logic                      take_wr;      // write taken this edge
    logic                      take_rd;      // read answered this edge
    logic                      dcs_wr;       // write to device control
    logic                      dyn_sel;      // selected ep is 1..4
    logic [1:0]                idx;          // index of selected ep
    logic [31:0]               read_word;    // value for the read mux
    logic [`IRQ_W-1:0]         ev;           // events of this cycle
    logic [`IRQ_W-1:0]         clr;          // status bits being read
    logic [`NUM_EP-1:0][`SZ_CFG_W-1:0]   tx_cfg;   // size per endpoint
    logic [`NUM_EP-1:0][`SZ_CFG_W-1:0]   rx_cfg;   // size per endpoint
    logic [`NUM_EP-1:0][`ADDR_CFG_W-1:0] tx_at;    // start per endpoint
    logic [`NUM_EP-1:0][`ADDR_CFG_W-1:0] rx_at;    // start per endpoint

    // byte-lane merge of the low half word
    function automatic logic [15:0] merge_lanes(input logic [15:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0]  be);
        merge_lanes = {be[1] ? wd[15:8] : old[15:8],
                       be[0] ? wd[7:0]  : old[7:0]};
    endfunction : merge_lanes

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: id, three comparators and suspend
    pin_sync #(
        .WIDTH (5)
    ) u_pins (
        .clk_i   (CLOCK_I),
        .rst_b_i (RST_B_I),
        .pin_i   ({SUSPEND_I, ID_I, ABOVE_VBUS_VALID_I,
                   ABOVE_A_VALID_I, ABOVE_SESS_END_I}),
        .sync_o  (pins)
    );

    assign suspended = pins[4];
    assign b_pin     = pins[3];

    always_comb begin
        if (pins[2]) begin
            level = `VBUS_ABOVE_VBUS_VLD;
        end else if (pins[1]) begin
            level = `VBUS_ABOVE_A_VALID;
        end else if (pins[0]) begin
            level = `VBUS_ABOVE_SESS_END;
        end else begin
            level = `VBUS_BELOW_SESS_END;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode; one wait cycle, then the answer
    assign req       = AVS_READ_I | AVS_WRITE_I;
    assign take_wr   = AVS_WRITE_I && st.phase == BUS_ANSWER;
    assign take_rd   = AVS_READ_I && st.phase == BUS_ANSWER;
    assign dcs_wr    = take_wr && AVS_ADDRESS_I == `OFS_DEV_CTRL;
    assign dyn_sel   = st.ep_sel >= 3'h1 && st.ep_sel <= 3'h4;
    assign idx       = 2'(st.ep_sel - 3'h1);

    // read mux, captured into the data flops one edge before the answer
    always_comb begin
        read_word = `RST_WORD;
        case (AVS_ADDRESS_I)
            `OFS_DEV_CTRL: begin
                read_word[`DCS_B_ROLE] = st.b_role;
                // host and speed flags held low
                read_word[`DCS_FULL_SPEED] = 1'b0;
                read_word[`DCS_LOW_SPEED]  = 1'b0;
                read_word[`DCS_HOST_ROLE]  = 1'b0;
                read_word[`DCS_VBUS_HI:`DCS_VBUS_LO] = st.vbus;
                read_word[`DCS_SESSION] = st.session;
            end
            `OFS_IRQ_STATUS: read_word[`IRQ_W-1:0] = st.irq_status;
            `OFS_IRQ_MASK:   read_word[`IRQ_W-1:0] = st.irq_mask;
            `OFS_EP_SELECT:  read_word[`EP_SEL_W-1:0] = st.ep_sel;
            `OFS_TX_SIZE:    read_word[`SZ_CFG_W-1:0] = tx_cfg[st.ep_sel];
            `OFS_RX_SIZE:    read_word[`SZ_CFG_W-1:0] = rx_cfg[st.ep_sel];
            `OFS_TX_ADDR:    read_word[`ADDR_CFG_W-1:0] = tx_at[st.ep_sel];
            `OFS_RX_ADDR:    read_word[`ADDR_CFG_W-1:0] = rx_at[st.ep_sel];
            // unmapped offsets read as zero
            default:         read_word = `RST_WORD;
        endcase
        // selections above four have no buffer and read as zero
        if (st.ep_sel > 3'h4 && AVS_ADDRESS_I >= `OFS_TX_SIZE) begin
            read_word = `RST_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st           = st;
        ev                = '0;
        clr               = '0;
        next_st.srp_pulse = 1'b0;
        next_st.b_role    = b_pin;
        next_st.vbus      = level;
        if (level != st.vbus) begin
            ev[`IRQ_VBUS_CHANGE] = 1'b1;
        end

        if (st.b_role && !dcs_wr) begin
            if (!st.session && st.vbus >= `VBUS_ABOVE_A_VALID) begin
                next_st.session = 1'b1;
            end else if (st.session &&
                         st.vbus == `VBUS_BELOW_SESS_END) begin
                next_st.session = 1'b0;
            end
        end

        // bus phase: capture read data, then answer
        case (st.phase)
            BUS_IDLE: begin
                if (req) begin
                    next_st.phase = BUS_ANSWER;
                    next_st.rdata = read_word;
                end
            end
            BUS_ANSWER: begin
                next_st.phase = BUS_IDLE;
            end
            default: begin
                next_st.phase = BUS_IDLE;
            end
        endcase

        // register writes take effect at the answering edge
        if (take_wr && AVS_BYTEENABLE_I[0]) begin
            case (AVS_ADDRESS_I)
                `OFS_DEV_CTRL: begin
                    if (AVS_WRITEDATA_I[`DCS_SESSION]) begin
                        if (!st.session) begin
                            next_st.session = 1'b1;
                            if (st.b_role) begin
                                next_st.srp_pulse    = 1'b1;
                                ev[`IRQ_SRP_START]   = 1'b1;
                            end
                        end
                    end else if (st.session) begin
                        if (suspended) begin
                            next_st.session   = 1'b0;
                            next_st.soft_disc = 1'b1;
                        end else if (!st.b_role) begin
                            next_st.session = 1'b0;
                        end
                    end
                end
                `OFS_IRQ_MASK: begin
                    next_st.irq_mask = AVS_WRITEDATA_I[`IRQ_W-1:0];
                end
                `OFS_EP_SELECT: begin
                    next_st.ep_sel = AVS_WRITEDATA_I[`EP_SEL_W-1:0];
                end
                `OFS_TX_SIZE: begin
                    if (dyn_sel) begin
                        next_st.tx_size[idx] =
                            AVS_WRITEDATA_I[`SZ_CFG_W-1:0];
                    end
                end
                `OFS_RX_SIZE: begin
                    if (dyn_sel) begin
                        next_st.rx_size[idx] =
                            AVS_WRITEDATA_I[`SZ_CFG_W-1:0];
                    end
                end
                default: begin
                    // other offsets take no byte-zero write
                end
            endcase
        end

        // start addresses span two byte lanes
        if (take_wr && dyn_sel && AVS_ADDRESS_I == `OFS_TX_ADDR) begin
            next_st.tx_addr[idx] = `ADDR_CFG_W'(merge_lanes(
                {3'h0, st.tx_addr[idx]}, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I));
        end
        if (take_wr && dyn_sel && AVS_ADDRESS_I == `OFS_RX_ADDR) begin
            next_st.rx_addr[idx] = `ADDR_CFG_W'(merge_lanes(
                {3'h0, st.rx_addr[idx]}, AVS_WRITEDATA_I,
                AVS_BYTEENABLE_I));
        end

        // session edges raise events; a new session ends a disconnect
        if (!st.session && next_st.session) begin
            ev[`IRQ_SESS_START] = 1'b1;
            next_st.soft_disc   = 1'b0;
        end
        if (st.session && !next_st.session) begin
            ev[`IRQ_SESS_END] = 1'b1;
        end

        // only bits that the read returned are cleared; a new event wins
        if (take_rd && AVS_ADDRESS_I == `OFS_IRQ_STATUS) begin
            clr = st.rdata[`IRQ_W-1:0];
        end
        next_st.irq_status = (st.irq_status & ~clr) | ev;
    end

    // state register
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st          <= '0;
            st.phase    <= BUS_IDLE;
            st.irq_mask <= `RST_IRQ_MASK;
            st.ep_sel   <= `RST_EP_SELECT;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign AVS_WAITREQUEST_O = req && st.phase == BUS_IDLE;
    assign AVS_READDATA_O    = st.rdata;
    assign SESSION_O         = st.session;
    assign SRP_START_O       = st.srp_pulse;
    assign SOFT_DISCONNECT_O = st.soft_disc;
    assign IRQ_O             = |(st.irq_status & st.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // endpoint buffer placement
    // endpoint zero is fixed
    assign tx_cfg[0] = {1'b0, `EP0_SIZE_CODE};
    assign rx_cfg[0] = {1'b0, `EP0_SIZE_CODE};
    assign tx_at[0]  = `EP0_START;
    assign rx_at[0]  = `EP0_START;

    for (genvar e = 1; e < `NUM_EP; e++) begin : g_dyn
        assign tx_cfg[e] = st.tx_size[e-1];
        assign rx_cfg[e] = st.rx_size[e-1];
        assign tx_at[e]  = st.tx_addr[e-1];
        assign rx_at[e]  = st.rx_addr[e-1];
    end

    for (genvar e = 0; e < `NUM_EP; e++) begin : g_map
        ep_buffer_map u_tx (
            .clk_i       (CLOCK_I),
            .rst_b_i     (RST_B_I),
            .size_code_i (tx_cfg[e][3:0]),
            .double_i    (tx_cfg[e][`SZ_DOUBLE_BIT]),
            .start_i     (tx_at[e]),
            .base_o      (TX_BUF_BASE_O[e*`BUF_BASE_W +: `BUF_BASE_W]),
            .bytes_o     (TX_BUF_SIZE_O[e*`BUF_BYTES_W +: `BUF_BYTES_W])
        );
        ep_buffer_map u_rx (
            .clk_i       (CLOCK_I),
            .rst_b_i     (RST_B_I),
            .size_code_i (rx_cfg[e][3:0]),
            .double_i    (rx_cfg[e][`SZ_DOUBLE_BIT]),
            .start_i     (rx_at[e]),
            .base_o      (RX_BUF_BASE_O[e*`BUF_BASE_W +: `BUF_BASE_W]),
            .bytes_o     (RX_BUF_SIZE_O[e*`BUF_BYTES_W +: `BUF_BYTES_W])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);

    a_role_read: assert property (
        (take_rd && AVS_ADDRESS_I == `OFS_DEV_CTRL)
        |-> AVS_READDATA_O[`DCS_B_ROLE] == $past(st.b_role))
        else $error("role bit does not match id pin");
    a_full_speed_low: assert property (
        (take_rd && AVS_ADDRESS_I == `OFS_DEV_CTRL)
        |-> !AVS_READDATA_O[`DCS_FULL_SPEED])
        else $error("full speed flag set without host role");
    a_low_speed_low: assert property (
        (take_rd && AVS_ADDRESS_I == `OFS_DEV_CTRL)
        |-> !AVS_READDATA_O[`DCS_LOW_SPEED])
        else $error("low speed flag set without host role");
    a_vbus_field: assert property (
        (take_rd && AVS_ADDRESS_I == `OFS_DEV_CTRL)
        |-> AVS_READDATA_O[`DCS_VBUS_HI:`DCS_VBUS_LO]
            == $past(st.vbus))
        else $error("vbus field does not match comparators");
    a_host_role_low: assert property (
        (take_rd && AVS_ADDRESS_I == `OFS_DEV_CTRL)
        |-> !AVS_READDATA_O[`DCS_HOST_ROLE])
        else $error("host role flag set");
    a_b_session_start: assert property (
        (st.b_role && !st.session && !dcs_wr
         && st.vbus >= `VBUS_ABOVE_A_VALID)
        |=> SESSION_O && st.irq_status[`IRQ_SESS_START])
        else $error("B device session not started by vbus");
    a_b_session_end: assert property (
        (st.b_role && st.session && !dcs_wr
         && st.vbus == `VBUS_BELOW_SESS_END) |=> !SESSION_O)
        else $error("B device session not ended by vbus");
    a_ep0_fixed: assert property (
        $past(RST_B_I) |-> TX_BUF_BASE_O[`BUF_BASE_W-1:0] == 16'h0000
        && RX_BUF_BASE_O[`BUF_BASE_W-1:0] == 16'h0000
        && TX_BUF_SIZE_O[`BUF_BYTES_W-1:0] == 20'h00040
        && RX_BUF_SIZE_O[`BUF_BYTES_W-1:0] == 20'h00040)
        else $error("endpoint zero buffer moved or resized");
    a_ep0_ignore: assert property (
        (take_wr && !dyn_sel) |=> $stable(st.tx_size)
        && $stable(st.rx_size) && $stable(st.tx_addr)
        && $stable(st.rx_addr))
        else $error("endpoint zero configuration was written");
    // a B device may legally restart at once, which ends the flag
    a_disconnect: assert property (
        (dcs_wr && suspended && st.session && AVS_BYTEENABLE_I[0]
         && !AVS_WRITEDATA_I[`DCS_SESSION])
        |=> (!SESSION_O && SOFT_DISCONNECT_O) ##1
            (SOFT_DISCONNECT_O || SESSION_O))
        else $error("software disconnect not performed");

endmodule : otg_session_ctrl

// ---- verif/usb_peer_model.sv ----
`timescale 1ns/1ps

// far-side peer: id pin and vbus comparators, thermometer coded
module usb_peer_model (
    input  wire logic       b_role_i,
    input  wire logic [1:0] level_i,
    input  wire logic       suspend_i,
    output logic            id_o,
    output logic            sess_end_o,
    output logic            a_valid_o,
    output logic            vbus_valid_o,
    output logic            suspend_o
);
    // a real supply never shows a higher comparator without the lower
    assign id_o         = b_role_i;
    assign sess_end_o   = level_i >= 2'h1;
    assign a_valid_o    = level_i >= 2'h2;
    assign vbus_valid_o = level_i == 2'h3;
    assign suspend_o    = suspend_i;
endmodule : usb_peer_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps

module tb;
    import otg_session_pkg::*;
    logic        clk = 0, rst_b = 0, rd = 0, wr = 0, brl = 0, sus = 0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [1:0]  lvl = 2'h0;
    logic        wq, id, se, av, vv, sp, ses, srp, sd, irq;
    logic        srp_seen = 0;
    logic [79:0] txb, rxb;
    logic [99:0] txs, rxs;
    int          n_fail = 0, comparisons = 0, cyc = 0;
    always #12.5 clk = ~clk;
    usb_peer_model peer_u (.b_role_i(brl), .level_i(lvl), .suspend_i(sus),
        .id_o(id), .sess_end_o(se), .a_valid_o(av), .vbus_valid_o(vv),
        .suspend_o(sp));
    otg_session_ctrl dut_u (.CLOCK_I(clk), .RST_B_I(rst_b),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq), .ID_I(id),
        .ABOVE_SESS_END_I(se), .ABOVE_A_VALID_I(av),
        .ABOVE_VBUS_VALID_I(vv), .SUSPEND_I(sp), .SESSION_O(ses),
        .SRP_START_O(srp), .SOFT_DISCONNECT_O(sd), .IRQ_O(irq),
        .TX_BUF_BASE_O(txb), .TX_BUF_SIZE_O(txs),
        .RX_BUF_BASE_O(rxb), .RX_BUF_SIZE_O(rxs));
    ////////////////////////////////////////////////////////////////////
    // one avalon access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        // one more edge, so callers see what the access left behind
        @(posedge clk);
    endtask : bus
    task automatic chk(input string n, input logic [31:0] e, s);
        comparisons++;
        if (s !== e) begin
            $display("mismatch %s exp %h got %h", n, e, s);
            n_fail++;
        end
    endtask : chk
    // pins need three edges to reach the vbus field; two spare for the session
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask : settle
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////
    // a device: every vbus code, host and speed flags stay clear
    task automatic t_levels();
        for (int l = 0; l < 4; l++) begin
            lvl <= l[1:0];
            settle();
            bus(1'b1, 6'h00, 32'h0);
            bus(1'b0, 6'h00, 32'h0);
            chk("dev ctrl", {27'h0, l[1:0], 3'h0}, q);
        end
        $display("levels done");
    endtask : t_levels
    // a device session by software, then clear while suspended
    task automatic t_a_session();
        bus(1'b1, 6'h00, 32'h1);
        chk("session", 32'h1, {31'h0, ses});
        chk("no srp", 32'h0, {31'h0, srp_seen});
        sus <= 1'b1;
        settle();
        bus(1'b1, 6'h00, 32'h0);
        chk("softdisc", 32'h1, {30'h0, ses, sd});
        sus <= 1'b0;
        $display("a session done");
    endtask : t_a_session
    // b device: srp request, hardware start and end, masked irq
    task automatic t_b_session();
        brl <= 1'b1;
        lvl <= 2'h1;
        bus(1'b1, 6'h08, 32'h9);
        settle();
        bus(1'b0, 6'h04, 32'h0);
        bus(1'b1, 6'h00, 32'h1);
        bus(1'b0, 6'h04, 32'h0);
        chk("srp", 32'h8, q & 32'h8);
        chk("srp pin", 32'h1, {31'h0, srp_seen});
        // a b device cannot end its session by software unless suspended
        bus(1'b1, 6'h00, 32'h0);
        chk("b keeps", 32'h2, {30'h0, ses, sd});
        lvl <= 2'h0;
        settle();
        bus(1'b0, 6'h04, 32'h0);
        lvl <= 2'h2;
        settle();
        chk("hw start", 32'h3, {30'h0, ses, irq});
        bus(1'b0, 6'h00, 32'h0);
        chk("dev ctrl b", 32'h91, q);
        bus(1'b0, 6'h04, 32'h0);
        chk("irq clr", 32'h0, {31'h0, irq});
        lvl <= 2'h0;
        settle();
        chk("hw end", 32'h0, {31'h0, ses});
        $display("b session done");
    endtask : t_b_session
    // fixed endpoint zero, sizing of endpoint two, select zero ignored
    task automatic t_buffers();
        bus(1'b1, 6'h0c, 32'h2);
        bus(1'b1, 6'h10, 32'h15);
        bus(1'b1, 6'h18, 32'h8);
        bus(1'b1, 6'h14, 32'h2);
        bus(1'b1, 6'h1c, 32'h48);
        bus(1'b1, 6'h0c, 32'h0);
        bus(1'b1, 6'h10, 32'h0f);
        bus(1'b1, 6'h18, 32'h7);
        @(posedge clk);
        chk("ep0 tx base", 32'h0, {16'h0, txb[15:0]});
        chk("ep0 rx base", 32'h0, {16'h0, rxb[15:0]});
        chk("ep0 tx size", 32'h40, {12'h0, txs[19:0]});
        chk("ep0 rx size", 32'h40, {12'h0, rxs[19:0]});
        chk("ep2 tx size", 32'h200, {12'h0, txs[40+:20]});
        chk("ep2 tx base", 32'h40, {16'h0, txb[32+:16]});
        chk("ep2 rx size", 32'h20, {12'h0, rxs[40+:20]});
        chk("ep2 rx base", 32'h240, {16'h0, rxb[32+:16]});
        bus(1'b0, 6'h20, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("buffers done");
    endtask : t_buffers
    // the srp pulse lasts one cycle, so keep a sticky copy
    always @(posedge clk) if (srp) srp_seen <= 1'b1;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_levels();
        t_a_session();
        t_b_session();
        t_buffers();
        test_done();
    end
endmodule : tb
